// File: src/asoi_cfg.svh
// Constants for the sample output interface block
`ifndef ASOI_CFG_SVH
`define ASOI_CFG_SVH
`define ASOI_DATA_W       8
`define ASOI_PIPE_DEPTH   3
`define ASOI_FIFO_DEPTH   8
`define ASOI_CLK_PERIOD_NS 10
`define ASOI_PD_TIME_NS   200
`define ASOI_PD_CYCLES    ((`ASOI_PD_TIME_NS + `ASOI_CLK_PERIOD_NS - 1) / `ASOI_CLK_PERIOD_NS)
`define ASOI_MIDSCALE     8'h80
`endif

// File: src/asoi_pkg.sv
// Types for the sample output interface block
package asoi_pkg;
   typedef enum logic [1:0] {
      ASOI_ACTIVE  = 2'b00,  // Converting
      ASOI_RECOVER = 2'b11,  // Waiting out recovery time
      ASOI_DOWN    = 2'b01   // Powered down
   } asoi_state_type;
endpackage

// File: src/asoi_fifo.sv
// Small valid/ready FIFO held in flip-flops
`timescale 1ns/100ps
module asoi_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clock,
   input  wire logic             rst_n,
   input  wire logic             clear,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_reg [DEPTH];   // Storage words
   logic [AW-1:0]    wr_reg, wr_next;   // Write index
   logic [AW-1:0]    rd_reg, rd_next;   // Read index
   logic [AW:0]      cnt_reg, cnt_next; // Fill level
   logic             push, pop;         // Handshake strobes

   // Handshakes from honest full and empty
   assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rd_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Next pointers and level
   always_comb begin
      wr_next  = wr_reg;
      rd_next  = rd_reg;
      cnt_next = cnt_reg;
      if (clear) begin
         wr_next  = '0;
         rd_next  = '0;
         cnt_next = '0;
      end else begin
         if (push) wr_next = (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
         if (pop)  rd_next = (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
         if (push && !pop) cnt_next = cnt_reg + 1'b1;
         if (pop && !push) cnt_next = cnt_reg - 1'b1;
      end
   end

   // Register pointers and storage
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         wr_reg  <= '0;
         rd_reg  <= '0;
         cnt_reg <= '0;
         for (int i = 0; i < DEPTH; i++) mem_reg[i] <= '0;
      end else begin
         wr_reg  <= wr_next;
         rd_reg  <= rd_next;
         cnt_reg <= cnt_next;
         if (push && !clear) mem_reg[wr_reg] <= in_data;
      end
   end
endmodule

// File: src/asoi_top.sv
// Digital output side of the eight bit sampling converter
`timescale 1ns/100ps
`include "asoi_cfg.svh"
module asoi_top (
   input  wire logic                   clock,
   input  wire logic                   rst_n,
   input  wire logic                   sample_clock,
   input  wire logic [`ASOI_DATA_W-1:0] conv_code,
   input  wire logic                   power_down_select,
   output logic [`ASOI_DATA_W-1:0]     sample_output_bits,
   output logic [`ASOI_DATA_W-1:0]     sample_output_oe,
   output logic                        data_valid,
   output logic                        reference_on,
   output logic                        fifo_valid,
   input  wire logic                   fifo_ready,
   output logic [`ASOI_DATA_W-1:0]     fifo_data,
   output logic                        sample_dropped
);
   localparam int PDC = `ASOI_PD_CYCLES;

   asoi_pkg::asoi_state_type state_reg, state_next; // Power state
   logic [7:0] tmr_reg, tmr_next;                    // Recovery timer
   logic [7:0] pd_tmr_reg, pd_tmr_next;              // Power down timer
   logic       sclk_d_reg;                           // Last sample clock level
   logic       edge_s;                               // Rising edge of sample clock
   logic [`ASOI_DATA_W-1:0] pipe_reg [`ASOI_PIPE_DEPTH]; // Conversion stages
   logic [`ASOI_DATA_W-1:0] pipe_next [`ASOI_PIPE_DEPTH];
   logic [1:0] fill_reg, fill_next;                  // Valid stage count
   logic [`ASOI_DATA_W-1:0] out_reg, out_next;       // Output word
   logic       oe_reg, oe_next;                      // Output drive
   logic       val_reg, val_next;                    // Word valid
   logic       drop_reg, drop_next;                  // Lost word pulse
   logic       f_in_ready;                           // FIFO room

   // Edge detect on the sampled clock input
   assign edge_s = sample_clock && !sclk_d_reg;

   // Power state, timers and pipeline next values
   always_comb begin
      state_next  = state_reg;
      tmr_next    = tmr_reg;
      pd_tmr_next = pd_tmr_reg;
      fill_next   = fill_reg;
      out_next    = out_reg;
      oe_next     = oe_reg;
      val_next    = 1'b0;
      drop_next   = 1'b0;
      for (int i = 0; i < `ASOI_PIPE_DEPTH; i++) pipe_next[i] = pipe_reg[i];
      case (state_reg)
         asoi_pkg::ASOI_ACTIVE: begin
            if (power_down_select) begin
               // Enter low power; outputs released at once
               state_next  = asoi_pkg::ASOI_DOWN;
               oe_next     = 1'b0;
               fill_next   = 2'd0;
               pd_tmr_next = 8'(PDC);
            end
         end
         asoi_pkg::ASOI_DOWN: begin
            oe_next = 1'b0;
            // Count out the host's wait before it trusts the released pins
            if (pd_tmr_reg != 8'h00) pd_tmr_next = pd_tmr_reg - 8'h01;
            // Release starts the full recovery count
            if (!power_down_select) begin
               state_next = asoi_pkg::ASOI_RECOVER;
               tmr_next   = 8'(PDC);
            end
         end
         asoi_pkg::ASOI_RECOVER: begin
            // Held word is driven again while recovery runs
            oe_next = 1'b1;
            if (power_down_select) begin
               state_next = asoi_pkg::ASOI_DOWN;
               oe_next    = 1'b0;
            end else if (tmr_reg == 8'h01) begin
               state_next = asoi_pkg::ASOI_ACTIVE;
               fill_next  = 2'd0;
            end else begin
               tmr_next = tmr_reg - 8'h01;
            end
         end
         default: state_next = asoi_pkg::ASOI_DOWN;
      endcase
      // Pipeline shifts on each sample edge while converting
      if (state_reg == asoi_pkg::ASOI_ACTIVE && !power_down_select && edge_s) begin
         pipe_next[0] = conv_code;
         for (int i = 1; i < `ASOI_PIPE_DEPTH; i++) pipe_next[i] = pipe_reg[i-1];
         out_next = pipe_reg[`ASOI_PIPE_DEPTH-1];
         oe_next  = 1'b1;
         if (fill_reg == 2'd3) begin
            val_next  = 1'b1;
            // Push lands next clock; a read this clock frees a slot in time
            drop_next = !f_in_ready && !(fifo_valid && fifo_ready);
         end else begin
            fill_next = fill_reg + 2'd1;
         end
      end
   end

   // Register state
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg  <= asoi_pkg::ASOI_ACTIVE;
         tmr_reg    <= 8'h00;
         pd_tmr_reg <= 8'h00;
         sclk_d_reg <= 1'b0;
         fill_reg   <= 2'd0;
         out_reg    <= 8'h00;
         oe_reg     <= 1'b1;
         val_reg    <= 1'b0;
         drop_reg   <= 1'b0;
         for (int i = 0; i < `ASOI_PIPE_DEPTH; i++) pipe_reg[i] <= 8'h00;
      end else begin
         state_reg  <= state_next;
         tmr_reg    <= tmr_next;
         pd_tmr_reg <= pd_tmr_next;
         sclk_d_reg <= sample_clock;
         fill_reg   <= fill_next;
         out_reg    <= out_next;
         oe_reg     <= oe_next;
         val_reg    <= val_next;
         drop_reg   <= drop_next;
         for (int i = 0; i < `ASOI_PIPE_DEPTH; i++) pipe_reg[i] <= pipe_next[i];
      end
   end

   // Output pins and status
   assign sample_output_bits = out_reg;
   assign sample_output_oe   = {`ASOI_DATA_W{oe_reg}};
   assign data_valid         = val_reg;
   assign sample_dropped     = drop_reg;
   assign reference_on       = 1'b1;

   // Capture buffer for valid words
   asoi_fifo #(.WIDTH(`ASOI_DATA_W), .DEPTH(`ASOI_FIFO_DEPTH)) u_fifo (
      .clock     (clock),
      .rst_n     (rst_n),
      .clear     (1'b0),
      .in_data   (out_reg),
      .in_valid  (val_reg),
      .in_ready  (f_in_ready),
      .out_data  (fifo_data),
      .out_valid (fifo_valid),
      .out_ready (fifo_ready)
   );

   // Sequences for the output path
   sequence s_edge_active;
      edge_s && state_reg == asoi_pkg::ASOI_ACTIVE && !power_down_select;
   endsequence

   // Power down request seen while converting
   sequence s_pd_request;
      state_reg == asoi_pkg::ASOI_ACTIVE && power_down_select;
   endsequence

   // Power down released, recovery about to start
   sequence s_wake;
      state_reg == asoi_pkg::ASOI_DOWN && !power_down_select;
   endsequence

   // Last recovery tick with power down still low
   sequence s_rec_last;
      state_reg == asoi_pkg::ASOI_RECOVER && !power_down_select && tmr_reg == 8'h01;
   endsequence

   property p_latency;
      logic [7:0] v;
      @(posedge clock) disable iff (!rst_n)
      (s_edge_active and fill_reg == 2'd3, v = pipe_reg[2]) |=> (sample_output_bits == v);
   endproperty
   a_latency: assert property (p_latency) else $error("Output word not three stages late");

   property p_hiz;
      @(posedge clock) disable iff (!rst_n)
      power_down_select && state_reg != asoi_pkg::ASOI_DOWN |=> sample_output_oe == 8'h00;
   endproperty
   a_hiz: assert property (p_hiz) else $error("Outputs driven in power down");

   property p_hold_down;
      @(posedge clock) disable iff (!rst_n)
      state_reg == asoi_pkg::ASOI_DOWN |-> sample_output_oe == 8'h00 && !data_valid;
   endproperty
   a_hold_down: assert property (p_hold_down) else $error("Activity while powered down");

   property p_recover;
      @(posedge clock) disable iff (!rst_n)
      $fell(power_down_select) && state_reg == asoi_pkg::ASOI_DOWN |=> !data_valid [*8];
   endproperty
   a_recover: assert property (p_recover) else $error("Valid word during recovery");

   property p_rec_len;
      @(posedge clock) disable iff (!rst_n)
      s_wake |=>
         (state_reg != asoi_pkg::ASOI_ACTIVE) [*8];
   endproperty
   a_rec_len: assert property (p_rec_len) else $error("Recovery ended early");

   property p_valid_edge;
      @(posedge clock) disable iff (!rst_n)
      data_valid |-> $past(edge_s) && $past(fill_reg) == 2'd3;
   endproperty
   a_valid_edge: assert property (p_valid_edge) else $error("Valid word without full pipe");

   property p_capture;
      @(posedge clock) disable iff (!rst_n)
      s_edge_active |=> pipe_reg[0] == $past(conv_code);
   endproperty
   a_capture: assert property (p_capture) else $error("Sample not taken on edge");

   property p_ref;
      @(posedge clock) disable iff (!rst_n) state_reg == asoi_pkg::ASOI_DOWN |-> reference_on;
   endproperty
   a_ref: assert property (p_ref) else $error("Reference off in power down");

   property p_drop;
      @(posedge clock) disable iff (!rst_n)
      (s_edge_active and fill_reg == 2'd3 && !f_in_ready && !(fifo_valid && fifo_ready)) |=> sample_dropped;
   endproperty
   a_drop: assert property (p_drop) else $error("Lost word not flagged");

   // Word with room in the buffer is not flagged lost
   property p_keep;
      @(posedge clock) disable iff (!rst_n)
      (s_edge_active and fill_reg == 2'd3 && (f_in_ready || (fifo_valid && fifo_ready))) |=> !sample_dropped;
   endproperty
   a_keep: assert property (p_keep) else $error("Accepted word flagged lost");

   // Power down loads the release wait counter
   property p_pd_load;
      @(posedge clock) disable iff (!rst_n)
      s_pd_request |=> state_reg == asoi_pkg::ASOI_DOWN && pd_tmr_reg == 8'(PDC);
   endproperty
   a_pd_load: assert property (p_pd_load) else $error("Power down wait not loaded");

   // Release wait counter runs down while powered down
   property p_pd_count;
      @(posedge clock) disable iff (!rst_n)
      state_reg == asoi_pkg::ASOI_DOWN && pd_tmr_reg != 8'h00 |=> pd_tmr_reg == $past(pd_tmr_reg) - 8'h01;
   endproperty
   a_pd_count: assert property (p_pd_count) else $error("Power down wait stalled");

   // Release loads the full recovery count
   property p_rec_load;
      @(posedge clock) disable iff (!rst_n)
      s_wake |=> state_reg == asoi_pkg::ASOI_RECOVER && tmr_reg == 8'(PDC);
   endproperty
   a_rec_load: assert property (p_rec_load) else $error("Recovery count not loaded");

   // Outputs drive again during recovery
   property p_rec_drive;
      @(posedge clock) disable iff (!rst_n)
      state_reg == asoi_pkg::ASOI_RECOVER && !power_down_select |=> sample_output_oe == 8'hFF;
   endproperty
   a_rec_drive: assert property (p_rec_drive) else $error("Outputs not driven in recovery");

   // No valid word while recovering
   property p_rec_quiet;
      @(posedge clock) disable iff (!rst_n)
      state_reg == asoi_pkg::ASOI_RECOVER |-> !data_valid;
   endproperty
   a_rec_quiet: assert property (p_rec_quiet) else $error("Valid word in recovery");

   // Recovery end empties the pipe fill count
   property p_rec_done;
      @(posedge clock) disable iff (!rst_n)
      s_rec_last |=> state_reg == asoi_pkg::ASOI_ACTIVE && fill_reg == 2'd0;
   endproperty
   a_rec_done: assert property (p_rec_done) else $error("Pipe not refilled after recovery");

   // Three edges refill the pipe before a word is valid
   property p_refill;
      @(posedge clock) disable iff (!rst_n)
      state_reg == asoi_pkg::ASOI_ACTIVE && fill_reg != 2'd3 |=> !data_valid;
   endproperty
   a_refill: assert property (p_refill) else $error("Valid word from a part filled pipe");

   // Word stands until the next accepted edge
   property p_word_stands;
      @(posedge clock) disable iff (!rst_n)
      !(edge_s && state_reg == asoi_pkg::ASOI_ACTIVE && !power_down_select) |=> $stable(sample_output_bits);
   endproperty
   a_word_stands: assert property (p_word_stands) else $error("Output word changed between edges");

   // Valid is a single clock pulse
   property p_valid_pulse;
      @(posedge clock) disable iff (!rst_n)
      data_valid |=> !data_valid;
   endproperty
   a_valid_pulse: assert property (p_valid_pulse) else $error("Valid held over two clocks");

   // A lost word is always a valid word
   property p_drop_valid;
      @(posedge clock) disable iff (!rst_n)
      sample_dropped |-> data_valid;
   endproperty
   a_drop_valid: assert property (p_drop_valid) else $error("Lost flag without a word");

   // An accepted word reaches the buffer
   property p_push;
      @(posedge clock) disable iff (!rst_n)
      data_valid && !sample_dropped |=> fifo_valid;
   endproperty
   a_push: assert property (p_push) else $error("Accepted word missing from buffer");
endmodule

// File: tb/asoi_capture_model.sv
// Capture logic model: makes the sample clock and takes FIFO words
`timescale 1ns/100ps
module asoi_capture_model (
   input  wire logic       clock,
   input  wire logic       rst_n,
   input  wire logic       run,
   input  wire logic [4:0] half_period,
   input  wire logic       stall,
   output logic            sample_clock,
   output logic            fifo_ready
);
   logic [4:0] cnt_reg;  // Clocks spent in the current phase

   // Equal high and low phases; parked low while stopped
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg      <= 5'h00;
         sample_clock <= 1'b0;
      end else if (!run) begin
         cnt_reg      <= 5'h00;
         sample_clock <= 1'b0;
      end else if (cnt_reg + 5'h01 >= half_period) begin
         cnt_reg      <= 5'h00;
         sample_clock <= ~sample_clock;
      end else begin
         cnt_reg <= cnt_reg + 5'h01;
      end
   end

   // Capture side stalls on command only
   assign fifo_ready = !stall;
endmodule

// File: tb/asoi_top_bench.sv
// Self-checking bench for the sample output interface
`timescale 1ns/100ps
`include "asoi_cfg.svh"
module asoi_top_bench;
   logic       clock = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] conv_code = 8'h00;
   logic       power_down_select = 1'b0;  // Held low until used
   logic       run = 1'b0;
   logic [4:0] half_period = 5'h01;
   logic       stall = 1'b0;
   logic       sample_clock, fifo_ready, data_valid, reference_on;
   logic       fifo_valid, sample_dropped;
   logic [7:0] sample_output_bits, sample_output_oe, fifo_data;
   logic [7:0] tbl [5] = '{8'hFF, 8'h80, 8'h7F, 8'h00, 8'h5A};  // Code table
   int         ti = 0;
   int         error_cnt = 0;
   int         n_tests = 0;
   int         dv_cnt = 0;
   logic       armed = 1'b1;     // Words expected from the design
   logic       sc_prev = 1'b0;
   logic       drop_seen = 1'b0;
   logic [7:0] sq [$];           // Captured codes in flight
   logic [7:0] fq [$];           // Words expected out of the FIFO

   asoi_top u_asoi_top (.clock(clock), .rst_n(rst_n), .sample_clock(sample_clock), .conv_code(conv_code),
      .power_down_select(power_down_select), .sample_output_bits(sample_output_bits),
      .sample_output_oe(sample_output_oe), .data_valid(data_valid), .reference_on(reference_on),
      .fifo_valid(fifo_valid), .fifo_ready(fifo_ready), .fifo_data(fifo_data), .sample_dropped(sample_dropped));
   asoi_capture_model u_asoi_capture_model (.clock(clock), .rst_n(rst_n), .run(run),
      .half_period(half_period), .stall(stall), .sample_clock(sample_clock), .fifo_ready(fifo_ready));

   // 100 MHz clock
   always #5 clock = ~clock;

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask

   // Cycle the code table so every coding corner is sampled
   always @(posedge clock) begin
      conv_code <= tbl[ti];
      ti <= (ti == 4) ? 0 : ti + 1;
   end

   // Monitor: tracks samples through the pipe and the FIFO
   always @(posedge clock) begin
      if (rst_n) begin
         if (armed && sample_clock && !sc_prev)
            sq.push_back(conv_code);
         sc_prev <= sample_clock;
         if (sample_dropped === 1'b1)
            drop_seen = 1'b1;
         if (data_valid === 1'b1) begin
            dv_cnt++;
            check({7'h00, armed}, 8'h01);
            check(8'(sq.size()), 8'h04);
            // Lost exactly when the buffer already holds a full load
            check({7'h00, sample_dropped}, {7'h00, fq.size() == `ASOI_FIFO_DEPTH});
            if (sq.size() > 0) begin
               check(sample_output_bits, sq[0]);
               if (sample_dropped !== 1'b1)
                  fq.push_back(sq[0]);
               void'(sq.pop_front());
            end
         end else begin
            check({7'h00, sample_dropped}, 8'h00);
         end
         if (fifo_valid === 1'b1 && fifo_ready === 1'b1) begin
            check({7'h00, fq.size() > 0}, 8'h01);
            if (fq.size() > 0)
               check(fifo_data, fq.pop_front());
         end
      end
   end

   task automatic t_reset();
      check(sample_output_oe, 8'hFF);
      check({7'h00, data_valid}, 8'h00);
      check({7'h00, fifo_valid}, 8'h00);
      check({7'h00, reference_on}, 8'h01);
      $display("test reset done");
   endtask

   task automatic t_stream(input logic [4:0] half);
      int c0;
      c0 = dv_cnt;
      half_period <= half;
      run <= 1'b1;
      cyc(40 * half);
      run <= 1'b0;
      cyc(8);
      check({7'h00, dv_cnt > c0 + 10}, 8'h01);
      $display("test stream half %0d done", half);
   endtask

   task automatic t_power_down();
      run <= 1'b0;
      cyc(4);
      armed <= 1'b0;
      power_down_select <= 1'b1;
      cyc(2);
      sq.delete();
      run <= 1'b1;
      cyc(`ASOI_PD_CYCLES);
      check(sample_output_oe, 8'h00);
      check({7'h00, reference_on}, 8'h01);
      run <= 1'b0;
      power_down_select <= 1'b0;
      // Drive returns one clock after recovery starts
      cyc(3);
      check(sample_output_oe, 8'hFF);
      cyc(`ASOI_PD_CYCLES);
      armed <= 1'b1;
      t_stream(5'h01);
      $display("test power down done");
   endtask

   task automatic t_full();
      stall <= 1'b1;
      run <= 1'b1;
      cyc(40);
      run <= 1'b0;
      cyc(6);
      check({7'h00, fifo_valid}, 8'h01);
      check({7'h00, drop_seen}, 8'h01);
      check(8'(fq.size()), 8'h08);
      stall <= 1'b0;
      cyc(20);
      check(8'(fq.size()), 8'h00);
      check({7'h00, fifo_valid}, 8'h00);
      $display("test fifo full done");
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #100000;
      error_cnt++;
      results();
   end

   initial begin
      cyc(3);
      rst_n <= 1'b1;
      cyc(1);
      t_reset();
      t_stream(5'h01);
      t_stream(5'h0A);
      t_power_down();
      t_full();
      results();
   end
endmodule
